//--- core/clm_load_map.vh
// Constants for the compact load unit: encodings, exception codes, operation kinds
`ifndef CLM_LOAD_MAP_VH
`define CLM_LOAD_MAP_VH

// 32-bit group and minor codes
`define CLM_MAJOR_B 6'h08
`define CLM_MINOR_MULTI 4'h7
`define CLM_MINOR_PAIR 4'h4
// 16-bit short byte load major code, value arbitrary
`define CLM_MAJOR_BYTE16 6'h02

// 32-bit field positions
`define CLM_MAJOR_HI 31
`define CLM_MAJOR_LO 26
`define CLM_LIST_HI 25
`define CLM_LIST_LO 21
`define CLM_BASE_HI 20
`define CLM_BASE_LO 16
`define CLM_MINOR_HI 15
`define CLM_MINOR_LO 12
`define CLM_OFS_HI 11

// Short byte load offset code that means minus one
`define CLM_OFS_NEG_CODE 4'hf
// Highest count code in the register list low bits
`define CLM_LIST_MAX_LO 4'h9

// Doubleword step in bytes
`define CLM_DW_STEP 64'h0000_0000_0000_0008

// Exception codes
`define CLM_EXC_TLB_REFILL 3'h0
`define CLM_EXC_TLB_INVALID 3'h1
`define CLM_EXC_BUS_ERROR 3'h2
`define CLM_EXC_ADDR_ERROR 3'h3
`define CLM_EXC_WATCH 3'h4
`define CLM_EXC_RESERVED 3'h5

// Operation kinds
`define CLM_KIND_BYTE 2'h0
`define CLM_KIND_MULTI 2'h1
`define CLM_KIND_PAIR 2'h2

// Reset values
`define CLM_ZERO64 64'h0000_0000_0000_0000

`endif

//--- core/clm_load_unit.v
// Decode and load sequencing for the short byte load, doubleword multiple and doubleword pair
`timescale 1ns/10ps
`include "clm_load_map.vh"

// How it works
// [RL1] Offset codes 0..e give 0..14, f gives -1
// [RL2] Byte load zero-extends one byte into target
// [RL3] 3-bit codes map to registers 16,17,2..7
// [RL4] Byte load: no bus error, no reserved
// [RL5] Multiple: group 001000, minor 0111, fields decoded
// [RL6] Multiple address is base plus signed offset
// [RL7] List codes pick 16.., 30, 31; others reserved
// [RL8] Fill left to right, address steps 8
// [RL9] Software keeps base out of the list
// [RL10] Pre-release-6: low three bits nonzero trap
// [RL11] Release-6 may load misaligned in hardware
// [RL12] Multiple exceptions; reserved when 64-bit off
// [RL13] Exception aborts; whole sequence reruns on return
// [RL14] One memory load per listed register
// [RL15] Interrupts held off during every sequence
// [RL16] Pair: group 001000, minor 0100, fields decoded
// [RL17] Pair loads two dwords into rd, rd+1
// [RL18] Pair does two loads, restarts on exception
// [RL19] Reserved list code raises reserved instruction
module clm_load_unit (
   input wire MCLK_IN,
   input wire SYS_RST_IN,
   input wire INSTR_VALID_IN,
   input wire INSTR_IS16_IN,
   input wire [31:0] INSTR_WORD_IN,
   output wire INSTR_READY_OUT,
   input wire CFG_REL6_IN,
   input wire CFG_MISALIGN_OK_IN,
   input wire CFG_EN64_IN,
   output wire [4:0] REGRD_IDX_OUT,
   input wire [63:0] REGRD_DATA_IN,
   output wire MEM_REQ_OUT,
   output wire [63:0] MEM_ADDR_OUT,
   output wire MEM_DWORD_OUT,
   input wire MEM_ACK_IN,
   input wire [63:0] MEM_DATA_IN,
   input wire MEM_EXC_IN,
   input wire [2:0] MEM_EXC_CODE_IN,
   output wire WB_VALID_OUT,
   output wire [4:0] WB_IDX_OUT,
   output wire [63:0] WB_DATA_OUT,
   output wire EXC_VALID_OUT,
   output wire [2:0] EXC_CODE_OUT,
   output wire DONE_OUT,
   output wire IRQ_HOLD_OUT
);

   localparam S_IDLE = 1'b0;
   localparam S_LOAD = 1'b1;

   // Short register code onto the reachable register set
   function [4:0] short_reg;
      input [2:0] code;
      begin
         case (code)
            3'h0: short_reg = 5'h10; // RL3
            3'h1: short_reg = 5'h11;
            3'h2: short_reg = 5'h02;
            3'h3: short_reg = 5'h03;
            3'h4: short_reg = 5'h04;
            3'h5: short_reg = 5'h05;
            3'h6: short_reg = 5'h06;
            3'h7: short_reg = 5'h07;
            default: short_reg = 5'h00;
         endcase
      end
   endfunction

   // Register loaded at position i of a list
   function [4:0] list_reg;
      input [4:0] list;
      input [3:0] i;
      begin
         if (i < list[3:0]) begin
            // Low list part runs 16..23, the ninth slot is register 30
            case (i)
               4'h0: list_reg = 5'h10; // RL7
               4'h1: list_reg = 5'h11;
               4'h2: list_reg = 5'h12;
               4'h3: list_reg = 5'h13;
               4'h4: list_reg = 5'h14;
               4'h5: list_reg = 5'h15;
               4'h6: list_reg = 5'h16;
               4'h7: list_reg = 5'h17;
               default: list_reg = 5'h1e;
            endcase
         end else begin
            list_reg = 5'd31; // RL7
         end
      end
   endfunction

   // Sequence control
   reg state_reg;
   reg state_next;
   reg [1:0] kind_reg;
   reg [1:0] kind_next;
   reg [63:0] addr_reg;
   reg [63:0] addr_next;
   reg [3:0] step_reg;
   reg [3:0] step_next;
   reg [3:0] last_reg;
   reg [3:0] last_next;
   reg [4:0] list_reg_q;
   reg [4:0] list_next;
   reg [4:0] dest_reg;
   reg [4:0] dest_next;
   reg dword_reg;
   reg dword_next;

   // Write-back, exception and completion pulses
   reg wb_valid_reg;
   reg wb_valid_next;
   reg [4:0] wb_idx_reg;
   reg [4:0] wb_idx_next;
   reg [63:0] wb_data_reg;
   reg [63:0] wb_data_next;
   reg exc_valid_reg;
   reg exc_valid_next;
   reg [2:0] exc_code_reg;
   reg [2:0] exc_code_next;
   reg done_reg;
   reg done_next;

   wire [5:0] major32 = INSTR_WORD_IN[`CLM_MAJOR_HI:`CLM_MAJOR_LO];
   wire [3:0] minor32 = INSTR_WORD_IN[`CLM_MINOR_HI:`CLM_MINOR_LO];
   wire [4:0] field_list = INSTR_WORD_IN[`CLM_LIST_HI:`CLM_LIST_LO];
   wire [4:0] field_base = INSTR_WORD_IN[`CLM_BASE_HI:`CLM_BASE_LO];
   wire [11:0] field_ofs = INSTR_WORD_IN[`CLM_OFS_HI:0];
   wire is_multi = !INSTR_IS16_IN && major32 == `CLM_MAJOR_B && minor32 == `CLM_MINOR_MULTI; // RL5
   wire is_pair = !INSTR_IS16_IN && major32 == `CLM_MAJOR_B && minor32 == `CLM_MINOR_PAIR; // RL16
   wire is_byte = INSTR_IS16_IN && INSTR_WORD_IN[15:10] == `CLM_MAJOR_BYTE16;

   // Short byte load fields
   wire [2:0] load_target_field = INSTR_WORD_IN[9:7];
   wire [2:0] short_base = INSTR_WORD_IN[6:4];
   wire [3:0] short_ofs = INSTR_WORD_IN[3:0];
   wire [63:0] short_ofs_ext = (short_ofs == `CLM_OFS_NEG_CODE) ?
      64'hffff_ffff_ffff_ffff : {60'h0, short_ofs}; // RL1
   wire [63:0] long_ofs_ext = {{52{field_ofs[11]}}, field_ofs}; // RL6

   // Base read is combinational; register file answers in the same cycle
   assign REGRD_IDX_OUT = INSTR_IS16_IN ? short_reg(short_base) : field_base;

   wire [63:0] ea_byte = REGRD_DATA_IN + short_ofs_ext; // RL1
   wire [63:0] ea_long = REGRD_DATA_IN + long_ofs_ext; // RL6
   // Release-6 parts without misalignment support still trap
   wire misalign_trap = ea_long[2:0] != 3'h0 && !(CFG_REL6_IN && CFG_MISALIGN_OK_IN); // RL10 RL11

   // Register list table: loads per code, reserved codes flagged
   // A flat table keeps the reserved gaps explicit rather than a range test
   reg list_ok;
   reg [3:0] list_count;
   always @* begin
      list_ok = 1'b1;
      case (field_list)
         5'h01: list_count = 4'h1; // RL7
         5'h02: list_count = 4'h2;
         5'h03: list_count = 4'h3;
         5'h04: list_count = 4'h4;
         5'h05: list_count = 4'h5;
         5'h06: list_count = 4'h6;
         5'h07: list_count = 4'h7;
         5'h08: list_count = 4'h8;
         5'h09: list_count = 4'h9;
         5'h10: list_count = 4'h1;
         5'h11: list_count = 4'h2;
         5'h12: list_count = 4'h3;
         5'h13: list_count = 4'h4;
         5'h14: list_count = 4'h5;
         5'h15: list_count = 4'h6;
         5'h16: list_count = 4'h7;
         5'h17: list_count = 4'h8;
         5'h18: list_count = 4'h9;
         5'h19: list_count = 4'ha;
         default: begin
            list_ok = 1'b0; // RL7 RL19
            list_count = 4'h0;
         end
      endcase
   end

   wire [4:0] cur_dest = (kind_reg == `CLM_KIND_MULTI) ? list_reg(list_reg_q, step_reg) :
      (kind_reg == `CLM_KIND_PAIR) ? dest_reg + {1'b0, step_reg} : dest_reg; // RL8 RL17
   wire [63:0] cur_data = (kind_reg == `CLM_KIND_BYTE) ? {56'h0, MEM_DATA_IN[7:0]} : MEM_DATA_IN; // RL2
   // Byte load faults limited to translation, address and watch kinds
   reg byte_exc_ok;
   always @* begin
      case (MEM_EXC_CODE_IN)
         `CLM_EXC_TLB_REFILL: byte_exc_ok = 1'b1; // RL4
         `CLM_EXC_TLB_INVALID: byte_exc_ok = 1'b1;
         `CLM_EXC_ADDR_ERROR: byte_exc_ok = 1'b1;
         `CLM_EXC_WATCH: byte_exc_ok = 1'b1;
         default: byte_exc_ok = 1'b0;
      endcase
   end
   // Other byte faults, bus error among them, complete as a normal load
   wire exc_taken = MEM_EXC_IN && (kind_reg != `CLM_KIND_BYTE || byte_exc_ok); // RL4

   always @* begin
      state_next = state_reg;
      kind_next = kind_reg;
      addr_next = addr_reg;
      step_next = step_reg;
      last_next = last_reg;
      list_next = list_reg_q;
      dest_next = dest_reg;
      dword_next = dword_reg;
      wb_valid_next = 1'b0;
      wb_idx_next = wb_idx_reg;
      wb_data_next = wb_data_reg;
      exc_valid_next = 1'b0;
      exc_code_next = exc_code_reg;
      done_next = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (INSTR_VALID_IN) begin
               step_next = 4'h0;
               if (is_byte) begin
                  // No 64-bit or alignment check on the byte load
                  kind_next = `CLM_KIND_BYTE; // RL4
                  addr_next = ea_byte; // RL1
                  dest_next = short_reg(load_target_field); // RL3
                  dword_next = 1'b0;
                  last_next = 4'h0;
                  state_next = S_LOAD;
               end else if (is_multi || is_pair) begin
                  if (!CFG_EN64_IN) begin
                     exc_valid_next = 1'b1; // RL12
                     exc_code_next = `CLM_EXC_RESERVED;
                  end else if (is_multi && !list_ok) begin
                     exc_valid_next = 1'b1; // RL19
                     exc_code_next = `CLM_EXC_RESERVED;
                  end else if (misalign_trap) begin
                     exc_valid_next = 1'b1; // RL10
                     exc_code_next = `CLM_EXC_ADDR_ERROR;
                  end else begin
                     kind_next = is_multi ? `CLM_KIND_MULTI : `CLM_KIND_PAIR;
                     addr_next = ea_long; // RL6 RL17
                     list_next = field_list;
                     dest_next = field_list;
                     dword_next = 1'b1;
                     last_next = is_multi ? list_count - 4'h1 : 4'h1; // RL14 RL18
                     state_next = S_LOAD;
                  end
               end
            end
         end
         S_LOAD: begin
            if (MEM_ACK_IN) begin
               if (exc_taken) begin
                  // Partial writes stay; the rerun overwrites them from the first load
                  exc_valid_next = 1'b1; // RL13 RL18
                  exc_code_next = MEM_EXC_CODE_IN; // RL12
                  state_next = S_IDLE;
               end else begin
                  wb_valid_next = 1'b1; // RL2 RL8
                  wb_idx_next = cur_dest;
                  wb_data_next = cur_data;
                  addr_next = addr_reg + `CLM_DW_STEP; // RL8
                  step_next = step_reg + 4'h1; // RL14
                  if (step_reg == last_reg) begin
                     done_next = 1'b1;
                     state_next = S_IDLE;
                  end
               end
            end
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // Sequence control registers
   always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_reg <= S_IDLE;
         kind_reg <= `CLM_KIND_BYTE;
         dword_reg <= 1'b0;
         addr_reg <= `CLM_ZERO64;
         step_reg <= 4'h0;
         last_reg <= 4'h0;
         list_reg_q <= 5'h00;
         dest_reg <= 5'h00;
      end else begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         dword_reg <= dword_next;
         addr_reg <= addr_next;
         step_reg <= step_next;
         last_reg <= last_next;
         list_reg_q <= list_next;
         dest_reg <= dest_next;
      end
   end

   // Write-back outputs
   always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         wb_valid_reg <= 1'b0;
         wb_idx_reg <= 5'h00;
         wb_data_reg <= `CLM_ZERO64;
      end else begin
         wb_valid_reg <= wb_valid_next;
         wb_idx_reg <= wb_idx_next;
         wb_data_reg <= wb_data_next;
      end
   end

   // Exception and completion pulses
   always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         exc_valid_reg <= 1'b0;
         exc_code_reg <= 3'h0;
         done_reg <= 1'b0;
      end else begin
         exc_valid_reg <= exc_valid_next;
         exc_code_reg <= exc_code_next;
         done_reg <= done_next;
      end
   end

   assign INSTR_READY_OUT = state_reg == S_IDLE;
   assign MEM_REQ_OUT = state_reg == S_LOAD; // RL14
   assign MEM_ADDR_OUT = addr_reg;
   assign MEM_DWORD_OUT = dword_reg;
   assign WB_VALID_OUT = wb_valid_reg;
   assign WB_IDX_OUT = wb_idx_reg;
   assign WB_DATA_OUT = wb_data_reg;
   assign EXC_VALID_OUT = exc_valid_reg;
   assign EXC_CODE_OUT = exc_code_reg;
   assign DONE_OUT = done_reg;
   // Holding interrupts keeps the sequence short of a restart on every interrupt
   assign IRQ_HOLD_OUT = state_reg == S_LOAD; // RL15

endmodule // clm_load_unit

//--- tb/clm_load_chk.sv
// Port checker for the compact load unit
`timescale 1ns/10ps
module clm_load_chk (
   input wire MCLK_IN,
   input wire SYS_RST_IN,
   input wire INSTR_READY_OUT,
   input wire MEM_REQ_OUT,
   input wire [63:0] MEM_ADDR_OUT,
   input wire MEM_DWORD_OUT,
   input wire MEM_ACK_IN,
   input wire MEM_EXC_IN,
   input wire [2:0] MEM_EXC_CODE_IN,
   input wire WB_VALID_OUT,
   input wire [63:0] WB_DATA_OUT,
   input wire EXC_VALID_OUT,
   input wire [2:0] EXC_CODE_OUT,
   input wire DONE_OUT,
   input wire IRQ_HOLD_OUT
);
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (SYS_RST_IN);
   wire good = MEM_REQ_OUT && MEM_ACK_IN && !MEM_EXC_IN;
   a_busy_not_ready: assert property (MEM_REQ_OUT |-> !INSTR_READY_OUT) else $error("ready while loading");
   a_irq_hold_req: assert property (IRQ_HOLD_OUT == MEM_REQ_OUT) else $error("hold differs from req");
   a_addr_held: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT))
      else $error("request dropped or moved");
   a_addr_step: assert property (good && MEM_DWORD_OUT
      |=> !MEM_REQ_OUT || MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 64'h8) else $error("address step wrong");
   a_wb_after_ack: assert property (good |=> WB_VALID_OUT && !EXC_VALID_OUT) else $error("no write after ack");
   a_fault_exc: assert property (MEM_REQ_OUT && MEM_ACK_IN && MEM_EXC_IN && MEM_DWORD_OUT
      |=> EXC_VALID_OUT && EXC_CODE_OUT == $past(MEM_EXC_CODE_IN) && !MEM_REQ_OUT) else $error("fault lost");
   a_byte_bus_err: assert property (MEM_REQ_OUT && MEM_ACK_IN && MEM_EXC_IN && !MEM_DWORD_OUT
      && MEM_EXC_CODE_IN == 3'h2 |=> WB_VALID_OUT && !EXC_VALID_OUT) else $error("byte bus error shown");
   a_byte_zext: assert property (good && !MEM_DWORD_OUT |=> WB_DATA_OUT[63:8] == 56'h0) else $error("byte not zero");
   a_end_idle: assert property (DONE_OUT || EXC_VALID_OUT |-> INSTR_READY_OUT && !MEM_REQ_OUT)
      else $error("busy at end");
endmodule // clm_load_chk
bind clm_load_unit clm_load_chk i_clm_load_chk (.*);

//--- tb/clm_mem_model.sv
// Memory load path model answering after a random wait of zero to two cycles
`timescale 1ns/10ps
module clm_mem_model (
   input wire clk_in,
   input wire req_in,
   input wire [63:0] addr_in,
   input wire [63:0] fault_addr_in,
   input wire [2:0] fault_code_in,
   output wire ack_out,
   output wire [63:0] data_out,
   output wire exc_out,
   output wire [2:0] code_out
);
   reg [1:0] wait_reg = 2'h0;
   wire [63:0] word = {~addr_in[31:0], addr_in[31:0]};
   assign ack_out = req_in && wait_reg == 2'h0;
   // Inverted outside the ack cycle so a stale word never looks valid
   assign data_out = ack_out ? word : ~word;
   assign exc_out = ack_out && addr_in == fault_addr_in;
   assign code_out = exc_out ? fault_code_in : ~fault_code_in;
   always @(posedge clk_in) begin
      if (!req_in || ack_out) begin
         wait_reg <= 2'($urandom % 3);
      end else begin
         wait_reg <= wait_reg - 2'h1;
      end
   end
endmodule // clm_mem_model

//--- tb/tb_top.sv
// Self-checking bench for the compact load unit
`timescale 1ns/10ps
`include "clm_load_map.vh"
module tb_top;
   reg clk = 0, rst = 1, iv = 0, i16 = 0, rel6 = 0, mok = 0, en64 = 1;
   reg [31:0] iw = 0;
   reg [63:0] bv = 0, fa = ~64'h0, b, a;
   reg [2:0] fc = 0, r;
   reg [4:0] l, r0;
   reg [11:0] o;
   wire rdy, req, dw, ack, mx, wbv, exv, done, hold;
   wire [4:0] ridx, widx;
   wire [63:0] ma, md, wd;
   wire [2:0] mc, ec;
   reg [69:0] q[$];
   integer n_mismatch = 0, checked = 0, i, j, k, n;
   always #20 clk = ~clk;
   clm_load_unit i_clm_load_unit (.MCLK_IN(clk), .SYS_RST_IN(rst), .INSTR_VALID_IN(iv), .INSTR_IS16_IN(i16),
      .INSTR_WORD_IN(iw), .INSTR_READY_OUT(rdy), .CFG_REL6_IN(rel6), .CFG_MISALIGN_OK_IN(mok), .CFG_EN64_IN(en64),
      .REGRD_IDX_OUT(ridx), .REGRD_DATA_IN(bv), .MEM_REQ_OUT(req), .MEM_ADDR_OUT(ma), .MEM_DWORD_OUT(dw),
      .MEM_ACK_IN(ack), .MEM_DATA_IN(md), .MEM_EXC_IN(mx), .MEM_EXC_CODE_IN(mc), .WB_VALID_OUT(wbv),
      .WB_IDX_OUT(widx), .WB_DATA_OUT(wd), .EXC_VALID_OUT(exv), .EXC_CODE_OUT(ec), .DONE_OUT(done), .IRQ_HOLD_OUT(hold));
   clm_mem_model i_clm_mem_model (.clk_in(clk), .req_in(req), .addr_in(ma), .fault_addr_in(fa),
      .fault_code_in(fc), .ack_out(ack), .data_out(md), .exc_out(mx), .code_out(mc));
   function [63:0] mf(input [63:0] x);
      mf = {~x[31:0], x[31:0]};
   endfunction
   task chk(input [69:0] seen, input [69:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED result exp %h seen %h", exp, seen);
      end
   endtask
   task e(input x, input [4:0] ri, input [63:0] d);
      q.push_back({x, ri, d});
   endtask
   task go(input s, input [31:0] w, input [63:0] base, input [4:0] bi);
      iv <= 1;
      i16 <= s;
      iw <= w;
      bv <= base;
      @(posedge clk);
      chk({65'h0, ridx}, {65'h0, bi});
      iv <= 0;
      k = 0;
      do begin
         @(posedge clk);
         k = k + 1;
      end while (done !== 1'b1 && exv !== 1'b1 && k < 300);
      if (k >= 300) n_mismatch++;
   endtask
   task stop_test;
      if (n_mismatch == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Pulses are looked at mid-cycle, clear of the edge that launches them
   always @(negedge clk) begin
      if (!rst && (wbv === 1'b1 || exv === 1'b1)) begin
         if (q.size() == 0) chk(70'h0, ~70'h0);
         else chk({exv, exv ? 5'h0 : widx, exv ? {61'h0, ec} : wd}, q.pop_front());
      end
   end
   initial begin
      void'($urandom(61));
      repeat (16) @(posedge clk);
      rst <= 0;
      // Odd offsets also fault: a bus error stays hidden, a watch is shown
      for (i = 0; i < 16; i++) begin
         b = {$urandom, $urandom};
         r = 3'(i + 3);
         a = b + (i == 15 ? ~64'h0 : 64'(i));
         fa <= i[0] ? a : ~64'h0;
         fc <= i == 13 ? `CLM_EXC_WATCH : `CLM_EXC_BUS_ERROR;
         r0 = i % 8 < 2 ? 5'(16 + i % 8) : 5'(i % 8);
         if (i == 13) e(1, 0, `CLM_EXC_WATCH);
         else e(0, r < 2 ? 5'h10 + 5'(r) : 5'(r), {56'h0, a[7:0]});
         go(1, {16'h0, 6'h02, r, 3'(i), 4'(i)}, b, r0);
      end
      fa <= ~64'h0;
      // Every list code, then a few with 64-bit operations off; base 3 is never listed
      for (j = 0; j < 36; j++) begin
         l = 5'(j);
         en64 <= j < 32;
         b = {$urandom, $urandom} & ~64'h7;
         o = 12'($urandom) & 12'hff8;
         a = b + {{52{o[11]}}, o};
         n = l[3:0];
         if (j >= 32 || n > 9 || l == 0) e(1, 0, `CLM_EXC_RESERVED);
         else begin
            for (i = 0; i < n; i++) begin
               e(0, i == 8 ? 5'd30 : 5'(16 + i), mf(a));
               a = a + 8;
            end
            if (l[4]) e(0, 5'd31, mf(a));
         end
         go(0, {6'h08, l, 5'h3, 4'h7, o}, b, 5'h3);
      end
      // Alignment and mode cases, then a fault on the second load and a rerun
      for (j = 0; j < 26; j++) begin
         rel6 <= j[2];
         mok <= j[1];
         en64 <= j[2:0] != 3'h6;
         fc <= 3'(j % 5);
         r0 = j[3] ? 5'h10 : 5'($urandom % 27 + 4);
         b = {$urandom, $urandom} & ~64'h7 | (j[0] && j < 16 ? 64'h4 : 64'h0);
         o = 12'($urandom) & 12'hff8;
         a = b + {{52{o[11]}}, o};
         fa <= j >= 16 ? a + 8 : ~64'h0;
         if (j[2:0] == 6) e(1, 0, `CLM_EXC_RESERVED);
         else if (j[0] && j < 16 && !(j[2] && j[1])) e(1, 0, `CLM_EXC_ADDR_ERROR);
         else begin
            e(0, r0, mf(a));
            if (j < 16) e(0, r0 + 5'h1, mf(a + 8));
            else e(1, 0, 64'(j % 5));
         end
         go(0, {6'h08, j[3] ? 5'h02 : r0, 5'h3, j[3] ? 4'h7 : 4'h4, o}, b, 5'h3);
         if (j >= 16) begin
            fa <= ~64'h0;
            en64 <= 1;
            e(0, r0, mf(a));
            e(0, r0 + 5'h1, mf(a + 8));
            go(0, {6'h08, j[3] ? 5'h02 : r0, 5'h3, j[3] ? 4'h7 : 4'h4, o}, b, 5'h3);
         end
      end
      chk(70'(q.size()), 70'h0);
      stop_test;
   end
   initial begin
      #2000000;
      n_mismatch++;
      stop_test;
   end
endmodule // tb_top
